//--- core/acc_pkg.sv
package acc_pkg;

	// register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CSR_W = 8;

	// byte offsets of the registers
	localparam logic [ADDR_W-1:0] OFF_CSR = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_BIT_SET = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_BIT_CLR = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATE = 8'h14;

	// control/status field positions
	localparam int BIT_POWER_OFF = 7;
	localparam int BIT_BANDGAP = 6;
	localparam int BIT_RESULT = 5;
	localparam int BIT_FLAG = 4;
	localparam int BIT_ENABLE = 3;
	localparam int BIT_RESERVED = 2;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_MODE_LO = 0;

	// event status / mask layout
	localparam int EVT_W = 2;
	localparam int EVT_TRIGGER = 0;
	localparam int EVT_REF_READY = 1;

	// state register layout
	localparam int ST_REF_ON = 0;
	localparam int ST_REF_READY = 1;
	localparam int ST_CMP_ON = 2;

	// reset values
	localparam logic [CSR_W-1:0] CSR_RESET = 8'h00;
	localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// reference start-up time
	localparam int CLK_PERIOD_NS = 20;
	localparam int REF_STARTUP_NS = 10000;
	localparam int REF_START_CYCLES =
		(REF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REF_CNT_W = 10;

	// analog input code width and default bandgap code
	localparam int ANA_W = 12;
	localparam logic [ANA_W-1:0] BANDGAP_CODE = 12'h0_3E8;

	typedef enum logic [1:0]
	{
		MODE_TOGGLE = 2'b00,
		MODE_RESERVED = 2'b01,
		MODE_FALL = 2'b10,
		MODE_RISE = 2'b11
	} acc_mode_e;

	typedef enum logic [1:0]
	{
		WS_COLLECT = 2'b00,
		WS_RESP = 2'b01
	} acc_wstate_e;

	typedef struct packed
	{
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} acc_axil_req_s;

	typedef struct packed
	{
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} acc_axil_rsp_s;

endpackage

//--- core/acc_compare.sv
`timescale 1ns/1ns
module acc_compare
#(
	parameter logic [acc_pkg::ANA_W-1:0] BANDGAP_LEVEL = acc_pkg::BANDGAP_CODE
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// analog levels as codes
	input wire logic [acc_pkg::ANA_W-1:0] positiveInput,
	input wire logic [acc_pkg::ANA_W-1:0] negativeInput,
	// control
	input wire logic bandgapSelect,
	input wire logic powerOff,
	// results
	output logic resultLive,
	output logic riseEvent,
	output logic fallEvent
);
	import acc_pkg::*;

	logic [ANA_W-1:0] plusLevel;
	logic sampleReg;
	logic sampleNext;
	logic prevReg;
	logic prevNext;

	always_comb
	begin
		// bandgap replaces the positive pin when selected [R6]
		plusLevel = bandgapSelect ? BANDGAP_LEVEL : positiveInput;
		// unpowered comparator reads low [R4]
		resultLive = !powerOff && (plusLevel > negativeInput); // [R1]
		sampleNext = resultLive; // [R18]
		prevNext = sampleReg;
		riseEvent = sampleReg && !prevReg; // [R18]
		fallEvent = !sampleReg && prevReg;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sampleReg <= 1'b0;
			prevReg <= 1'b0;
		end
		else
		begin
			sampleReg <= sampleNext;
			prevReg <= prevNext;
		end
	end
endmodule

//--- core/acc_evt_status.sv
`timescale 1ns/1ns
module acc_evt_status
#(
	parameter int WIDTH = acc_pkg::EVT_W
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// event pulses
	input wire logic [WIDTH-1:0] eventIn,
	// software access
	input wire logic clearWrite,
	input wire logic maskWrite,
	input wire logic [WIDTH-1:0] writeData,
	// state
	output logic [WIDTH-1:0] status,
	output logic [WIDTH-1:0] mask,
	output logic irq
);
	import acc_pkg::*;

	logic [WIDTH-1:0] statusReg;
	logic [WIDTH-1:0] statusNext;
	logic [WIDTH-1:0] maskReg;
	logic [WIDTH-1:0] maskNext;
	logic irqReg;
	logic irqNext;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			// set wins over a simultaneous write-one clear
			assign statusNext[i] = eventIn[i] ||
				(statusReg[i] && !(clearWrite && writeData[i]));
		end
	endgenerate

	always_comb
	begin
		maskNext = maskWrite ? writeData : maskReg;
		// a set mask bit keeps its event off the interrupt
		irqNext = |(statusNext & ~maskNext);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			statusReg <= '0;
			maskReg <= '0;
			irqReg <= 1'b0;
		end
		else
		begin
			statusReg <= statusNext;
			maskReg <= maskNext;
			irqReg <= irqNext;
		end
	end

	assign status = statusReg;
	assign mask = maskReg;
	assign irq = irqReg;
endmodule

//--- core/acc_top.sv
`timescale 1ns/1ns
// Summary of operation
// R1: result high when plus input exceeds minus
// R2: result bit five reads live comparator output
// R3: comparator has its own interrupt request
// R4: bit seven powers the comparator off
// R5: software disables interrupt before toggling power bit
// R6: bit six swaps plus pin for bandgap
// R7: bit two reserved, reads zero, ignores writes
// R8: flag bit four set on matching event
// R9: request needs flag, enable bit three, global enable
// R10: vector execution clears the flag
// R11: writing one clears flag, zero keeps it
// R12: mode bits: toggle, reserved, falling, rising
// R13: software disables interrupt before changing mode
// R14: single-bit set/clear writes back set flag
// R15: reference powered by brown-out enable or bandgap
// R16: software waits reference start-up before use
// R17: software may drop reference before power-down
// R18: edges found by comparing successive clocked samples
module acc_top
#(
	parameter logic [acc_pkg::ANA_W-1:0] BANDGAP_LEVEL = acc_pkg::BANDGAP_CODE
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register bus
	input wire acc_pkg::acc_axil_req_s axiReq,
	output acc_pkg::acc_axil_rsp_s axiRsp,
	// analog inputs as codes
	input wire logic [acc_pkg::ANA_W-1:0] positiveInput,
	input wire logic [acc_pkg::ANA_W-1:0] negativeInput,
	// processor side
	input wire logic globalIrqEnable,
	input wire logic irqVectorAck,
	input wire logic brownoutEnableFuse,
	output logic comparatorIrqReq,
	// power and system interrupt
	output logic referencePowerOn,
	output logic comparatorPowerOn,
	output logic irq
);
	import acc_pkg::*;

	// control/status register content
	logic powerOffReg, powerOffNext;
	logic bandgapReg, bandgapNext;
	logic flagReg, flagNext;
	logic enableReg, enableNext;
	acc_mode_e modeReg, modeNext;
	logic irqReqReg, irqReqNext;
	// reference power and start-up, comparator power
	logic refOnReg, refOnNext;
	logic [REF_CNT_W-1:0] refCntReg, refCntNext;
	logic refReadyReg, refReadyNext;
	logic refReadyEvent;
	logic cmpOnReg, cmpOnNext;
	// bus state; ready bits are aw, w, ar from high to low
	acc_wstate_e wStateReg, wStateNext;
	logic awHeldReg, awHeldNext;
	logic wHeldReg, wHeldNext;
	logic [ADDR_W-1:0] wAddrReg, wAddrNext;
	logic [DATA_W-1:0] wDataReg, wDataNext;
	logic [3:0] wStrbReg, wStrbNext;
	logic bValidReg, bValidNext;
	logic [1:0] bRespReg, bRespNext;
	logic rValidReg, rValidNext;
	logic [DATA_W-1:0] rDataReg, rDataNext;
	logic [1:0] rRespReg, rRespNext;
	logic [2:0] readyReg, readyNext;
	// datapath
	logic resultLive, riseEvent, fallEvent, trigger;
	logic doWrite, csrWrite, evtClearWrite, evtMaskWrite;
	logic [CSR_W-1:0] csrImage, csrWriteData;
	logic [EVT_W-1:0] evtStatus, evtMask;

	function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
		isMapped = (addr == OFF_CSR) || (addr == OFF_BIT_SET) ||
			(addr == OFF_BIT_CLR) || (addr == OFF_EVT_STATUS) ||
			(addr == OFF_EVT_MASK) || (addr == OFF_STATE);
	endfunction
	function automatic logic modeMatch(input acc_mode_e mode,
		input logic rise, input logic fall);
		case (mode) // [R12]
			MODE_TOGGLE: modeMatch = rise || fall;
			MODE_FALL: modeMatch = fall;
			MODE_RISE: modeMatch = rise;
			default: modeMatch = 1'b0;
		endcase
	endfunction
	acc_compare #(
		.BANDGAP_LEVEL(BANDGAP_LEVEL)
	) u_compare (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.positiveInput(positiveInput),
		.negativeInput(negativeInput),
		.bandgapSelect(bandgapReg),
		.powerOff(powerOffReg),
		.resultLive(resultLive),
		.riseEvent(riseEvent),
		.fallEvent(fallEvent)
	);
	acc_evt_status #(
		.WIDTH(EVT_W)
	) u_evt (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.eventIn({refReadyEvent, trigger}),
		.clearWrite(evtClearWrite),
		.maskWrite(evtMaskWrite),
		.writeData(wDataReg[EVT_W-1:0]),
		.status(evtStatus),
		.mask(evtMask),
		.irq(irq)
	);
	// register image as software sees it
	always_comb
	begin
		csrImage = CSR_RESET;
		csrImage[BIT_POWER_OFF] = powerOffReg;
		csrImage[BIT_BANDGAP] = bandgapReg;
		csrImage[BIT_RESULT] = resultLive; // [R2]
		csrImage[BIT_FLAG] = flagReg;
		csrImage[BIT_ENABLE] = enableReg;
		csrImage[BIT_RESERVED] = 1'b0; // [R7]
		csrImage[BIT_MODE_HI:BIT_MODE_LO] = modeReg;
	end
	// write decode; bit set/clear is a read-modify-write of the image
	always_comb
	begin
		doWrite = (wStateReg == WS_COLLECT) && awHeldReg && wHeldReg;
		csrWrite = 1'b0;
		csrWriteData = csrImage;
		evtClearWrite = 1'b0;
		evtMaskWrite = 1'b0;
		if (doWrite && wStrbReg[0])
		begin
			csrWrite = (wAddrReg == OFF_CSR) ||
				(wAddrReg == OFF_BIT_SET) || (wAddrReg == OFF_BIT_CLR);
			if (wAddrReg == OFF_CSR)
				csrWriteData = wDataReg[CSR_W-1:0];
			if (wAddrReg == OFF_BIT_SET)
				csrWriteData[wDataReg[2:0]] = 1'b1; // [R14]
			if (wAddrReg == OFF_BIT_CLR)
				csrWriteData[wDataReg[2:0]] = 1'b0; // [R14]
			evtClearWrite = (wAddrReg == OFF_EVT_STATUS);
			evtMaskWrite = (wAddrReg == OFF_EVT_MASK);
		end
	end

	// control/status next values
	always_comb
	begin
		trigger = modeMatch(modeReg, riseEvent, fallEvent); // [R8]
		powerOffNext = powerOffReg;
		bandgapNext = bandgapReg;
		enableNext = enableReg;
		modeNext = modeReg;
		if (csrWrite)
		begin
			powerOffNext = csrWriteData[BIT_POWER_OFF]; // [R4]
			bandgapNext = csrWriteData[BIT_BANDGAP]; // [R6]
			enableNext = csrWriteData[BIT_ENABLE];
			modeNext = acc_mode_e'(csrWriteData[BIT_MODE_HI:BIT_MODE_LO]);
		end
		// a new event wins over any clear in the same cycle
		flagNext = trigger || (flagReg && !irqVectorAck && // [R10]
			!(csrWrite && csrWriteData[BIT_FLAG])); // [R11]
		irqReqNext = flagReg && enableReg && globalIrqEnable; // [R9] [R3]
		refOnNext = brownoutEnableFuse || bandgapReg; // [R15]
		cmpOnNext = !powerOffReg; // [R4]
	end

	// reference start-up tracking
	always_comb
	begin
		refCntNext = refCntReg;
		refReadyNext = refReadyReg;
		refReadyEvent = 1'b0;
		if (!refOnReg)
		begin
			refCntNext = '0;
			refReadyNext = 1'b0;
		end
		else if (!refReadyReg &&
			refCntReg == REF_CNT_W'(REF_START_CYCLES - 1))
		begin
			refReadyNext = 1'b1;
			refReadyEvent = 1'b1;
		end
		else if (!refReadyReg)
			refCntNext = refCntReg + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			powerOffReg <= CSR_RESET[BIT_POWER_OFF];
			bandgapReg <= CSR_RESET[BIT_BANDGAP];
			flagReg <= CSR_RESET[BIT_FLAG];
			enableReg <= CSR_RESET[BIT_ENABLE];
			modeReg <= MODE_TOGGLE;
			irqReqReg <= 1'b0;
			refOnReg <= 1'b0;
			refCntReg <= '0;
			refReadyReg <= 1'b0;
			cmpOnReg <= 1'b0;
		end
		else
		begin
			powerOffReg <= powerOffNext;
			bandgapReg <= bandgapNext;
			flagReg <= flagNext;
			enableReg <= enableNext;
			modeReg <= modeNext;
			irqReqReg <= irqReqNext;
			refOnReg <= refOnNext;
			refCntReg <= refCntNext;
			refReadyReg <= refReadyNext;
			cmpOnReg <= cmpOnNext;
		end
	end

	// bus slave next values
	always_comb
	begin
		awHeldNext = awHeldReg;
		wHeldNext = wHeldReg;
		wAddrNext = wAddrReg;
		wDataNext = wDataReg;
		wStrbNext = wStrbReg;
		wStateNext = wStateReg;
		bValidNext = bValidReg;
		bRespNext = bRespReg;
		rValidNext = rValidReg;
		rDataNext = rDataReg;
		rRespNext = rRespReg;
		if (axiReq.awvalid && !awHeldReg)
		begin
			awHeldNext = 1'b1;
			wAddrNext = axiReq.awaddr;
		end
		if (axiReq.wvalid && !wHeldReg)
		begin
			wHeldNext = 1'b1;
			wDataNext = axiReq.wdata;
			wStrbNext = axiReq.wstrb;
		end
		case (wStateReg)
			WS_COLLECT:
			begin
				if (doWrite)
				begin
					bValidNext = 1'b1;
					bRespNext = isMapped(wAddrReg) ? RESP_OKAY : RESP_DECERR;
					wStateNext = WS_RESP;
				end
			end
			WS_RESP:
			begin
				if (axiReq.bready)
				begin
					bValidNext = 1'b0;
					awHeldNext = 1'b0;
					wHeldNext = 1'b0;
					wStateNext = WS_COLLECT;
				end
			end
			default: wStateNext = WS_COLLECT;
		endcase
		if (rValidReg)
		begin
			if (axiReq.rready)
				rValidNext = 1'b0;
		end
		else if (axiReq.arvalid)
		begin
			rValidNext = 1'b1;
			rRespNext = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_DECERR;
			rDataNext = '0;
			case (axiReq.araddr)
				OFF_CSR: rDataNext[CSR_W-1:0] = csrImage;
				OFF_EVT_STATUS: rDataNext[EVT_W-1:0] = evtStatus;
				OFF_EVT_MASK: rDataNext[EVT_W-1:0] = evtMask;
				OFF_STATE:
				begin
					rDataNext[ST_REF_ON] = refOnReg;
					rDataNext[ST_REF_READY] = refReadyReg;
					rDataNext[ST_CMP_ON] = cmpOnReg;
				end
				default: rDataNext = '0;
			endcase
		end
		// readies are registered so that they leave straight from flops
		readyNext = {!awHeldNext, !wHeldNext, !rValidNext};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wStateReg <= WS_COLLECT;
			awHeldReg <= 1'b0;
			wHeldReg <= 1'b0;
			wAddrReg <= '0;
			wDataReg <= '0;
			wStrbReg <= '0;
			bValidReg <= 1'b0;
			bRespReg <= RESP_OKAY;
			rValidReg <= 1'b0;
			rDataReg <= '0;
			rRespReg <= RESP_OKAY;
			readyReg <= 3'h7;
		end
		else
		begin
			wStateReg <= wStateNext;
			awHeldReg <= awHeldNext;
			wHeldReg <= wHeldNext;
			wAddrReg <= wAddrNext;
			wDataReg <= wDataNext;
			wStrbReg <= wStrbNext;
			bValidReg <= bValidNext;
			bRespReg <= bRespNext;
			rValidReg <= rValidNext;
			rDataReg <= rDataNext;
			rRespReg <= rRespNext;
			readyReg <= readyNext;
		end
	end

	assign axiRsp = {readyReg[2], readyReg[1], bValidReg, bRespReg,
		readyReg[0], rValidReg, rDataReg, rRespReg};

	assign comparatorIrqReq = irqReqReg;
	assign referencePowerOn = refOnReg;
	assign comparatorPowerOn = cmpOnReg;
endmodule

//--- bench/acc_analog_model.sv
`timescale 1ns/1ns
module acc_analog_model
(
	// clock
	input wire logic sys_clk,
	// wanted comparison outcome
	input wire logic plusAbove,
	// pin levels as codes
	output logic [acc_pkg::ANA_W-1:0] plusLevel,
	output logic [acc_pkg::ANA_W-1:0] minusLevel
);
	import acc_pkg::*;
	// minus sits between both plus levels and above the bandgap code
	always @(posedge sys_clk)
	begin
		plusLevel <= plusAbove ? 12'h0_800 : 12'h0_400;
		minusLevel <= 12'h0_600;
	end
endmodule

//--- bench/acc_assertions.sv
`timescale 1ns/1ns
module acc_assertions
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register bus
	input wire acc_pkg::acc_axil_req_s axiReq,
	input wire acc_pkg::acc_axil_rsp_s axiRsp,
	// processor side
	input wire logic globalIrqEnable,
	input wire logic irqVectorAck,
	input wire logic brownoutEnableFuse,
	input wire logic comparatorIrqReq,
	// power
	input wire logic referencePowerOn,
	input wire logic comparatorPowerOn
);
	import acc_pkg::*;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_REQ_GLOBAL: assert property (
		comparatorIrqReq |-> $past(globalIrqEnable))
		else $error("request without global enable");
	AST_VEC_CLEAR: assert property (
		irqVectorAck ##1 !irqVectorAck |=> !comparatorIrqReq)
		else $error("request stays after vector");
	AST_REF_FUSE: assert property (
		brownoutEnableFuse [*3] |-> referencePowerOn)
		else $error("reference off while fuse set");
	AST_PWR_FALL: assert property (
		$fell(comparatorPowerOn) |->
		$past(axiRsp.bvalid) && !$past(axiRsp.bvalid, 2))
		else $error("power dropped without write");
	AST_AW_HELD: assert property (
		axiReq.awvalid && axiRsp.awready |=> !axiRsp.awready)
		else $error("address ready while held");
	AST_W_HELD: assert property (
		axiReq.wvalid && axiRsp.wready |=> !axiRsp.wready [*2])
		else $error("data ready while held");
	AST_B_AFTER: assert property (axiReq.awvalid && axiRsp.awready
		&& axiReq.wvalid && axiRsp.wready |-> ##[1:2] axiRsp.bvalid)
		else $error("write answer late");
	AST_R_NEXT: assert property (
		axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read answer late");
	AST_AR_BLOCK: assert property (axiRsp.rvalid |-> !axiRsp.arready)
		else $error("address ready while data pending");
endmodule

bind acc_top acc_assertions i_acc_assertions
(
	.sys_clk,
	.rst_n,
	.axiReq,
	.axiRsp,
	.globalIrqEnable,
	.irqVectorAck,
	.brownoutEnableFuse,
	.comparatorIrqReq,
	.referencePowerOn,
	.comparatorPowerOn
);

//--- bench/tb.sv
`timescale 1ns/1ns
`define CHK(a, b) \
	begin \
		comparisons++; \
		if ((a) !== (b)) \
		begin \
			n_errors++; \
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); \
		end \
	end
module tb;
	import acc_pkg::*;
	logic sys_clk;
	logic rst_n;
	acc_axil_req_s axiReq;
	acc_axil_rsp_s axiRsp;
	logic [ANA_W-1:0] plusLevel;
	logic [ANA_W-1:0] minusLevel;
	logic plusAbove;
	logic globalIrqEnable;
	logic irqVectorAck;
	logic brownoutEnableFuse;
	logic comparatorIrqReq;
	logic referencePowerOn;
	logic comparatorPowerOn;
	logic irq;
	int n_errors;
	int comparisons;
	int cycles;
	logic [7:0] rd;
	logic [1:0] rsp;

	acc_top i_acc_top
	(
		.sys_clk,
		.rst_n,
		.axiReq,
		.axiRsp,
		.positiveInput(plusLevel),
		.negativeInput(minusLevel),
		.globalIrqEnable,
		.irqVectorAck,
		.brownoutEnableFuse,
		.comparatorIrqReq,
		.referencePowerOn,
		.comparatorPowerOn,
		.irq
	);
	acc_analog_model i_acc_analog_model
	(
		.sys_clk,
		.plusAbove,
		.plusLevel,
		.minusLevel
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic test_done();
		$display("mismatches %0d of %0d checks", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			test_done();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// bready and rready stay high, so each answer is taken when seen
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		axiReq.awaddr <= a;
		axiReq.awvalid <= 1'b1;
		axiReq.wdata <= {24'h00_0000, d};
		axiReq.wstrb <= 4'hF;
		axiReq.wvalid <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (axiRsp.awready)
				axiReq.awvalid <= 1'b0;
			if (axiRsp.wready)
				axiReq.wvalid <= 1'b0;
		end
		while (axiRsp.bvalid !== 1'b1);
		rsp = axiRsp.bresp;
	endtask

	task automatic rdr(input logic [7:0] a);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (axiRsp.arready)
				axiReq.arvalid <= 1'b0;
		end
		while (axiRsp.rvalid !== 1'b1);
		rd = axiRsp.rdata[7:0];
		rsp = axiRsp.rresp;
	endtask

	task automatic csr(input logic [7:0] m, input logic [7:0] e);
		rdr(OFF_CSR);
		`CHK(rd & m, e)
	endtask

	task automatic level(input logic v);
		plusAbove <= v;
		tick(6);
	endtask

	initial
	begin
		n_errors = 0;
		comparisons = 0;
		cycles = 0;
		rst_n = 1'b0;
		axiReq = '0;
		axiReq.bready = 1'b1;
		axiReq.rready = 1'b1;
		plusAbove = 1'b0;
		globalIrqEnable = 1'b0;
		irqVectorAck = 1'b0;
		brownoutEnableFuse = 1'b0;
		tick(20);
		rst_n <= 1'b1;
		tick(3);
		csr(8'hFF, CSR_RESET);
		wr(OFF_CSR, 8'h04);
		`CHK(rsp, RESP_OKAY)
		csr(8'hFF, 8'h00);
		level(1'b1);
		csr(8'h20, 8'h20);
		level(1'b0);
		csr(8'h20, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			wr(OFF_CSR, 8'h10 | m[7:0]);
			level(1'b1);
			csr(8'h10, {3'b000, m == 0 || m == 3, 4'h0});
			wr(OFF_CSR, 8'h10 | m[7:0]);
			level(1'b0);
			csr(8'h10, {3'b000, m == 0 || m == 2, 4'h0});
		end
		wr(OFF_CSR, 8'h10);
		level(1'b1);
		wr(OFF_CSR, 8'h00);
		csr(8'h10, 8'h10);
		wr(OFF_CSR, 8'h08);
		tick(3);
		`CHK(comparatorIrqReq, 1'b0)
		globalIrqEnable <= 1'b1;
		tick(3);
		`CHK(comparatorIrqReq, 1'b1)
		irqVectorAck <= 1'b1;
		tick(1);
		irqVectorAck <= 1'b0;
		tick(3);
		`CHK(comparatorIrqReq, 1'b0)
		csr(8'h10, 8'h00);
		level(1'b0);
		wr(OFF_CSR, 8'h18);
		csr(8'h18, 8'h08);
		level(1'b1);
		wr(OFF_BIT_CLR, 8'h03);
		csr(8'h18, 8'h00);
		globalIrqEnable <= 1'b0;
		wr(OFF_BIT_SET, 8'h06);
		tick(3);
		`CHK(referencePowerOn, 1'b1)
		tick(REF_START_CYCLES);
		rdr(OFF_STATE);
		`CHK(rd, 8'h07)
		csr(8'h60, 8'h40);
		wr(OFF_BIT_CLR, 8'h06);
		tick(6);
		`CHK(referencePowerOn, 1'b0)
		csr(8'h60, 8'h20);
		brownoutEnableFuse <= 1'b1;
		tick(4);
		`CHK(referencePowerOn, 1'b1)
		brownoutEnableFuse <= 1'b0;
		wr(OFF_CSR, 8'h80);
		tick(3);
		`CHK(comparatorPowerOn, 1'b0)
		csr(8'h20, 8'h00);
		wr(OFF_CSR, 8'h00);
		tick(8);
		`CHK(comparatorPowerOn, 1'b1)
		`CHK(irq, 1'b1)
		wr(OFF_EVT_MASK, 8'h03);
		tick(2);
		`CHK(irq, 1'b0)
		wr(OFF_EVT_MASK, 8'h00);
		tick(2);
		`CHK(irq, 1'b1)
		wr(OFF_EVT_STATUS, 8'h03);
		tick(2);
		`CHK(irq, 1'b0)
		rdr(OFF_EVT_STATUS);
		`CHK(rd, 8'h00)
		rdr(8'h20);
		`CHK(rsp, RESP_DECERR)
		`CHK(rd, 8'h00)
		wr(8'h20, 8'h01);
		`CHK(rsp, RESP_DECERR)
		test_done();
	end
endmodule
